//--- osd_frame_consts.svh
// constants for the on-screen-display frame timing block
// assumes a 10-bit register port address and one 40 MHz clock
`ifndef OSD_FRAME_CONSTS_SVH
`define OSD_FRAME_CONSTS_SVH

// register offsets; address bit 9 selects the display ram
`define OSD_A_CTRL 10'h000
`define OSD_A_VDLY 10'h001
`define OSD_A_HDLY 10'h002
`define OSD_A_CHGT 10'h003
`define OSD_A_COLR 10'h004
`define OSD_A_WROW 10'h005
`define OSD_A_WCOL 10'h006
`define OSD_A_WCFG 10'h007
`define OSD_A_DW 10'h008
`define OSD_A_DH 10'h009
`define OSD_A_STAT 10'h00a
`define OSD_RAM_BIT 9

// reset values
`define OSD_CTRL_RST 4'h0
`define OSD_VDLY_RST 8'h04
`define OSD_HDLY_RST 7'h0f
`define OSD_CHGT_RST 6'h10

// timing counts in dots and scan lines
`define OSD_FIX_HDOTS 11'h02f
`define OSD_PD_DOTS 11'h004
`define OSD_HSTEP_DOTS 11'h005
`define OSD_VFIX_LINES 11'h001
`define OSD_VSTEP_LINES 11'h004
`define OSD_DISP_DOTS 9'h12c
`define OSD_RETRACE_DOTS 11'h010
`define OSD_MULT_LO 10'h140
`define OSD_MULT_MID 10'h1e0
`define OSD_MULT_HI 10'h280
`define OSD_CHAR_DOTS 5'h0a
`define OSD_LAST_ROW 4'he
`define OSD_FONT_STEP 7'h10
`define OSD_FONT_LAST 4'hf

// fixed glyph codes
`define OSD_GLYPH_BLANK 7'h00
`define OSD_GLYPH_FULL 7'h7f
`define OSD_GLYPH_TEST 7'h7e

`endif

//--- osd_pkg.sv
// types shared by the on-screen-display frame timing block
// assumes nothing of its surroundings
package osd_pkg;
    typedef struct packed {
        logic full_res_sel;
        logic extended_res_sel;
        logic fast_blank_cfg;
        logic osd_en;
    } osd_ctrl_t;

    typedef struct packed {
        logic r;
        logic g;
        logic b;
    } osd_rgb_t;

    typedef enum logic [1:0] {V_WAIT, V_ROWS, V_DONE} osd_vstate_t;
endpackage : osd_pkg

//--- osd_dot_gen.sv
// dot pulse generator locked to the horizontal flyback rate
// assumes a flyback leading-edge pulse and a clock faster than the dot rate
`timescale 1ns/1ps
module osd_dot_gen (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // line timing
    input wire logic i_hedge,
    input wire logic [9:0] i_mult,
    output logic o_dot
);
    logic [15:0] cnt_r;
    logic [15:0] period_r;
    logic [15:0] acc_r;
    logic [16:0] sum;
    logic hit;
    logic [9:0] mult_q;
    logic mchg_r;
    logic [10:0] ndot_r;

    assign sum = {1'b0, acc_r} + 17'(i_mult);
    assign hit = (period_r != 16'h0000) && (sum >= {1'b0, period_r});

    // clocks per line, measured edge to edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 16'h0000;
            period_r <= 16'h0000;
        end else if (i_hedge) begin
            cnt_r <= 16'h0001;
            period_r <= cnt_r;
        end else if (cnt_r != 16'hffff) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // fractional accumulator: mult dots per measured line
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r <= 16'h0000;
            o_dot <= 1'b0;
        end else begin
            o_dot <= hit && !i_hedge;
            if (i_hedge) begin
                acc_r <= 16'(i_mult);
            end else if (hit) begin
                acc_r <= 16'(sum - {1'b0, period_r});
            end else if (period_r != 16'h0000) begin
                acc_r <= sum[15:0];
            end
        end
    end

    // dots per line and resolution changes, for the rate check
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mult_q <= 10'h000;
            mchg_r <= 1'b1;
            ndot_r <= 11'h000;
        end else begin
            mult_q <= i_mult;
            if (i_hedge) begin
                mchg_r <= 1'b0;
                ndot_r <= 11'h000;
            end else begin
                if (i_mult != mult_q) begin
                    mchg_r <= 1'b1;
                end
                if (o_dot) begin
                    ndot_r <= ndot_r + 11'h001;
                end
            end
        end
    end

    property p_linedots;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_hedge && !mchg_r && (i_mult == mult_q) && (period_r != 16'h0000) && (cnt_r == period_r))
            |-> ((ndot_r + 11'(o_dot)) == 11'(i_mult));
    endproperty
    a_linedots: assert property (p_linedots) else $error("dots per line differ from the multiple");
endmodule : osd_dot_gen

//--- osd_mem.sv
// display ram, glyph rom and register read-back latch
// assumes one clock; all read data leave through registers
`timescale 1ns/1ps
`include "osd_frame_consts.svh"
module osd_mem (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // host port
    input wire logic i_hwe,
    input wire logic i_hre,
    input wire logic i_hsel_ram,
    input wire logic [8:0] i_haddr,
    input wire logic [7:0] i_hwdata,
    input wire logic [15:0] i_hreg,
    output logic [15:0] o_hrdata,
    // fetch port
    input wire logic [8:0] i_faddr,
    output logic [7:0] o_fdata,
    // glyph port
    input wire logic [6:0] i_code,
    input wire logic [3:0] i_frow,
    output logic [9:0] o_glyph
);
    logic [7:0] ram [0:511];

    // fixed font; blank, full and test codes cannot be changed
    function automatic logic [9:0] glyph(input logic [6:0] c, input logic [3:0] r);
        logic [9:0] g;
        g = 10'h000;
        case (c)
            `OSD_GLYPH_BLANK: g = 10'h000;
            `OSD_GLYPH_FULL: g = 10'h3ff;
            `OSD_GLYPH_TEST: g = {r, r[1:0], r} ^ 10'h2b5;
            default: g = (r > 4'h1 && r < 4'he) ? {2'h0, c, 1'b0} : 10'h000;
        endcase
        return g;
    endfunction : glyph

    always_ff @(posedge i_clk) begin
        if (i_hwe) begin
            ram[i_haddr] <= i_hwdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 16'h0000;
            o_fdata <= 8'h00;
            o_glyph <= 10'h000;
        end else begin
            if (i_hre) begin
                o_hrdata <= i_hsel_ram ? {8'h00, ram[i_haddr]} : i_hreg;
            end
            o_fdata <= ram[i_faddr];
            o_glyph <= glyph(i_code, i_frow);
        end
    end
endmodule : osd_mem

//--- osd_frame_timing.sv
// frame format and output timing of the on-screen-display generator
// assumes synchronous flyback inputs and a dot rate below a third of the clock
// Operation
// - first dot 47 dots plus pulse width after hflyback; first line one line after vflyback
// - dot rate is 320, 480 or 640 times the line rate by resolution bits
// - double-width rows show only even column characters
// - at most 300 display dots per line; fewer where the retrace limit comes first
// - 320-dot mode shows about 24 characters; retrace takes the rest
// - 480 and 640 modes can show all 30 characters
// - halftone output active only inside an enabled window
// - fast-blank config bit changes only the fast-blank output
// - each colour output is character colour OR window colour
// - halftone output equals the window waveform, whatever the window colour
// - 128-glyph rom addressed by the seven-bit character code
// - codes 00 and 7f predefined, 7e test glyph, none changeable
// - scan lines in the frame follow each row's character height
// - vertical start moves four lines per step, never zero, default 4
// - horizontal start moves five dots per step, never zero, default 15
// - fast blank on characters or windows, or characters only when configured
`timescale 1ns/1ps
`include "osd_frame_consts.svh"
module osd_frame_timing (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // flyback inputs
    input wire logic I_HORIZ_FLYBACK_IN,
    input wire logic I_VERT_FLYBACK_IN,
    // register port
    input wire logic [9:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    // video outputs
    output osd_pkg::osd_rgb_t O_RGB,
    output logic O_HALFTONE_CLOCK_OUT,
    output logic O_FAST_BLANK_OUT
);
    import osd_pkg::*;

    osd_ctrl_t ctrl_r;
    logic [7:0] vdelay_r;
    logic [6:0] hdelay_r;
    logic [5:0] chgt_r;
    logic [5:0] colors_r;
    logic [7:0] win_rows_r;
    logic [9:0] win_cols_r;
    logic [3:0] win_cfg_r;
    logic [14:0] dw_r;
    logic [14:0] dh_r;
    logic [15:0] reg_rd;

    logic hf_q;
    logic vf_q;
    logic hedge;
    logic vedge;
    logic dot;
    logic [9:0] mult;
    logic [10:0] dot_cnt_r;
    logic [10:0] hstart;
    logic [10:0] hlim;
    logic [8:0] hpos_r;
    logic [4:0] cdot_r;
    logic [4:0] col_r;
    logic [4:0] fcol;
    logic [4:0] cw;
    logic [4:0] cstep;
    logic [3:0] bidx;
    logic h_act;
    logic in_disp;

    logic [10:0] line_cnt_r;
    logic [10:0] vstart;
    osd_vstate_t vstate_r;
    logic [3:0] row_r;
    logic [6:0] lir_r;
    logic [6:0] eh;
    logic [6:0] facc_r;
    logic [6:0] facc_sum;
    logic [3:0] frow_r;
    logic v_act;
    logic dw_cur;

    logic [7:0] fdata;
    logic [9:0] glyph;
    logic ccs_q;
    logic pix;
    logic chr_on;
    logic win_on;
    osd_rgb_t chr_col;
    osd_rgb_t win_col;

    // register writes
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_r <= osd_ctrl_t'(`OSD_CTRL_RST);
            vdelay_r <= `OSD_VDLY_RST;
            hdelay_r <= `OSD_HDLY_RST;
            chgt_r <= `OSD_CHGT_RST;
            colors_r <= 6'h00;
            win_rows_r <= 8'h00;
            win_cols_r <= 10'h000;
            win_cfg_r <= 4'h0;
            dw_r <= 15'h0000;
            dh_r <= 15'h0000;
        end else if (I_WR && !I_ADDR[`OSD_RAM_BIT]) begin
            case (I_ADDR)
                `OSD_A_CTRL: ctrl_r <= osd_ctrl_t'(I_WDATA[3:0]);
                `OSD_A_VDLY: begin
                    if (I_WDATA[7:0] != 8'h00) begin
                        vdelay_r <= I_WDATA[7:0];
                    end
                end
                `OSD_A_HDLY: begin
                    if (I_WDATA[6:0] != 7'h00) begin
                        hdelay_r <= I_WDATA[6:0];
                    end
                end
                `OSD_A_CHGT: chgt_r <= I_WDATA[5:0];
                `OSD_A_COLR: colors_r <= I_WDATA[5:0];
                `OSD_A_WROW: win_rows_r <= I_WDATA[7:0];
                `OSD_A_WCOL: win_cols_r <= {I_WDATA[12:8], I_WDATA[4:0]};
                `OSD_A_WCFG: win_cfg_r <= I_WDATA[3:0];
                `OSD_A_DW: dw_r <= I_WDATA[14:0];
                `OSD_A_DH: dh_r <= I_WDATA[14:0];
                default: ;
            endcase
        end
    end

    // register read mux; unmapped offsets read zero
    always_comb begin
        reg_rd = 16'h0000;
        case (I_ADDR)
            `OSD_A_CTRL: reg_rd = {12'h000, ctrl_r};
            `OSD_A_VDLY: reg_rd = {8'h00, vdelay_r};
            `OSD_A_HDLY: reg_rd = {9'h000, hdelay_r};
            `OSD_A_CHGT: reg_rd = {10'h000, chgt_r};
            `OSD_A_COLR: reg_rd = {10'h000, colors_r};
            `OSD_A_WROW: reg_rd = {8'h00, win_rows_r};
            `OSD_A_WCOL: reg_rd = {3'h0, win_cols_r[9:5], 3'h0, win_cols_r[4:0]};
            `OSD_A_WCFG: reg_rd = {12'h000, win_cfg_r};
            `OSD_A_DW: reg_rd = {1'b0, dw_r};
            `OSD_A_DH: reg_rd = {1'b0, dh_r};
            `OSD_A_STAT: reg_rd = {row_r, vstate_r, v_act, h_act, 1'b0, 7'h00};
            default: reg_rd = 16'h0000;
        endcase
    end

    // flyback leading edges
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            hf_q <= 1'b0;
            vf_q <= 1'b0;
        end else begin
            hf_q <= I_HORIZ_FLYBACK_IN;
            vf_q <= I_VERT_FLYBACK_IN;
        end
    end

    assign hedge = I_HORIZ_FLYBACK_IN && !hf_q;
    assign vedge = I_VERT_FLYBACK_IN && !vf_q;

    // dots per line from the resolution bits
    always_comb begin
        if (!ctrl_r.extended_res_sel) begin
            mult = `OSD_MULT_LO;
        end else if (!ctrl_r.full_res_sel) begin
            mult = `OSD_MULT_MID;
        end else begin
            mult = `OSD_MULT_HI;
        end
    end

    osd_dot_gen u_dot (
        .i_clk(I_CLK),
        .i_rst_n(I_RESET_N),
        .i_hedge(hedge),
        .i_mult(mult),
        .o_dot(dot)
    );

    // horizontal placement and visible limit
    assign hstart = `OSD_FIX_HDOTS + `OSD_PD_DOTS + 11'(hdelay_r) * `OSD_HSTEP_DOTS;
    assign hlim = 11'(mult) - `OSD_RETRACE_DOTS;
    assign in_disp = (dot_cnt_r >= hstart) && (hpos_r < `OSD_DISP_DOTS);
    assign h_act = in_disp && (dot_cnt_r < hlim);
    assign dw_cur = dw_r[row_r];
    assign cw = dw_cur ? 5'(`OSD_CHAR_DOTS << 1) : `OSD_CHAR_DOTS;
    assign cstep = dw_cur ? 5'h02 : 5'h01;
    assign fcol = (cdot_r == cw - 5'h01) ? col_r + cstep : col_r;
    assign bidx = dw_cur ? cdot_r[4:1] : cdot_r[3:0];

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            dot_cnt_r <= 11'h000;
        end else if (hedge) begin
            dot_cnt_r <= 11'h000;
        end else if (dot && dot_cnt_r != 11'h7ff) begin
            dot_cnt_r <= dot_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            hpos_r <= 9'h000;
            cdot_r <= 5'h00;
            col_r <= 5'h00;
        end else if (hedge) begin
            hpos_r <= 9'h000;
            cdot_r <= 5'h00;
            col_r <= 5'h00;
        end else if (dot && in_disp) begin
            hpos_r <= hpos_r + 9'h001;
            if (cdot_r == cw - 5'h01) begin
                cdot_r <= 5'h00;
                col_r <= col_r + cstep;
            end else begin
                cdot_r <= cdot_r + 5'h01;
            end
        end
    end

    // vertical placement and row sequencing
    assign vstart = `OSD_VFIX_LINES + 11'(vdelay_r) * `OSD_VSTEP_LINES;
    assign eh = dh_r[row_r] ? {chgt_r, 1'b0} : {1'b0, chgt_r};
    assign facc_sum = facc_r + `OSD_FONT_STEP;
    assign v_act = (vstate_r == V_ROWS);

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            line_cnt_r <= 11'h000;
        end else if (vedge) begin
            line_cnt_r <= 11'h000;
        end else if (hedge && line_cnt_r != 11'h7ff) begin
            line_cnt_r <= line_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            vstate_r <= V_WAIT;
            row_r <= 4'h0;
            lir_r <= 7'h00;
            facc_r <= 7'h00;
            frow_r <= 4'h0;
        end else if (vedge) begin
            vstate_r <= V_WAIT;
            row_r <= 4'h0;
            lir_r <= 7'h00;
            facc_r <= 7'h00;
            frow_r <= 4'h0;
        end else if (hedge) begin
            case (vstate_r)
                V_WAIT: begin
                    if (line_cnt_r == vstart - 11'h001) begin
                        vstate_r <= V_ROWS;
                    end
                end
                V_ROWS: begin
                    if (lir_r >= eh - 7'h01) begin
                        lir_r <= 7'h00;
                        facc_r <= 7'h00;
                        frow_r <= 4'h0;
                        if (row_r == `OSD_LAST_ROW) begin
                            vstate_r <= V_DONE;
                        end else begin
                            row_r <= row_r + 4'h1;
                        end
                    end else begin
                        lir_r <= lir_r + 7'h01;
                        if (facc_sum >= eh) begin
                            facc_r <= facc_sum - eh;
                            if (frow_r != `OSD_FONT_LAST) begin
                                frow_r <= frow_r + 4'h1;
                            end
                        end else begin
                            facc_r <= facc_sum;
                        end
                    end
                end
                V_DONE: vstate_r <= V_DONE;
                default: vstate_r <= V_WAIT;
            endcase
        end
    end

    osd_mem u_mem (
        .i_clk(I_CLK),
        .i_rst_n(I_RESET_N),
        .i_hwe(I_WR && I_ADDR[`OSD_RAM_BIT]),
        .i_hre(I_RD),
        .i_hsel_ram(I_ADDR[`OSD_RAM_BIT]),
        .i_haddr(I_ADDR[8:0]),
        .i_hwdata(I_WDATA[7:0]),
        .i_hreg(reg_rd),
        .o_hrdata(O_RDATA),
        .i_faddr({row_r, fcol}),
        .o_fdata(fdata),
        .i_code(fdata[6:0]),
        .i_frow(frow_r),
        .o_glyph(glyph)
    );

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ccs_q <= 1'b0;
        end else begin
            ccs_q <= fdata[7];
        end
    end

    // character and window waveforms
    assign pix = glyph[4'h9 - bidx];
    assign chr_on = v_act && h_act && pix;
    assign chr_col = chr_on ? osd_rgb_t'(ccs_q ? colors_r[5:3] : colors_r[2:0]) : osd_rgb_t'(3'h0);
    assign win_on = v_act && h_act && win_cfg_r[0]
        && (win_rows_r[3:0] <= win_rows_r[7:4]) && (row_r >= win_rows_r[3:0]) && (row_r <= win_rows_r[7:4])
        && (win_cols_r[4:0] <= win_cols_r[9:5]) && (col_r >= win_cols_r[4:0]) && (col_r <= win_cols_r[9:5]);
    assign win_col = win_on ? osd_rgb_t'(win_cfg_r[3:1]) : osd_rgb_t'(3'h0);

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_RGB <= osd_rgb_t'(3'h0);
            O_HALFTONE_CLOCK_OUT <= 1'b0;
            O_FAST_BLANK_OUT <= 1'b0;
        end else if (!ctrl_r.osd_en) begin
            O_RGB <= osd_rgb_t'(3'h0);
            O_HALFTONE_CLOCK_OUT <= 1'b0;
            O_FAST_BLANK_OUT <= 1'b0;
        end else begin
            O_RGB <= chr_col | win_col;
            O_HALFTONE_CLOCK_OUT <= win_on;
            O_FAST_BLANK_OUT <= chr_on || (!ctrl_r.fast_blank_cfg && win_on);
        end
    end

    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    property p_hrestart;
        hedge |=> (dot_cnt_r == 11'h000) && (hpos_r == 9'h000);
    endproperty
    a_hrestart: assert property (p_hrestart) else $error("dot counter not restarted");

    property p_vrestart;
        vedge |=> (line_cnt_r == 11'h000) && (row_r == 4'h0) && (vstate_r == V_WAIT);
    endproperty
    a_vrestart: assert property (p_vrestart) else $error("line counter not restarted");

    property p_hfirst;
        (h_act && !$past(h_act) && $stable(hdelay_r) && $stable(ctrl_r)) |-> (dot_cnt_r == hstart);
    endproperty
    a_hfirst: assert property (p_hfirst) else $error("first dot misplaced");

    property p_vfirst;
        (vstate_r == V_WAIT && hedge && !vedge && line_cnt_r == vstart - 11'h001) |=> v_act;
    endproperty
    a_vfirst: assert property (p_vfirst) else $error("first line misplaced");

    property p_mult;
        !ctrl_r.extended_res_sel |-> (mult == `OSD_MULT_LO);
    endproperty
    a_mult: assert property (p_mult) else $error("wrong dot multiple");

    property p_dwidth;
        (h_act && dw_cur) |-> !col_r[0];
    endproperty
    a_dwidth: assert property (p_dwidth) else $error("odd column shown in double width");

    property p_ndots;
        (hpos_r <= `OSD_DISP_DOTS)
            && (!(hedge && (dot_cnt_r >= hstart + 11'(`OSD_DISP_DOTS))) || (hpos_r == `OSD_DISP_DOTS));
    endproperty
    a_ndots: assert property (p_ndots) else $error("more than 300 dots");

    property p_retrace;
        (dot_cnt_r >= hlim) |=> (O_RGB == osd_rgb_t'(3'h0)) && !O_FAST_BLANK_OUT && !O_HALFTONE_CLOCK_OUT;
    endproperty
    a_retrace: assert property (p_retrace) else $error("dot shown in retrace");

    property p_vzero;
        (I_WR && I_ADDR == `OSD_A_VDLY && I_WDATA[7:0] == 8'h00) |=> $stable(vdelay_r) && (vdelay_r != 8'h00);
    endproperty
    a_vzero: assert property (p_vzero) else $error("zero vertical delay taken");

    property p_hzero;
        (I_WR && I_ADDR == `OSD_A_HDLY && I_WDATA[6:0] == 7'h00) |=> $stable(hdelay_r) && (hdelay_r != 7'h00);
    endproperty
    a_hzero: assert property (p_hzero) else $error("zero horizontal delay taken");

    property p_halftone;
        !win_on |=> !O_HALFTONE_CLOCK_OUT;
    endproperty
    a_halftone: assert property (p_halftone) else $error("halftone outside window");

    property p_fblank;
        (ctrl_r.fast_blank_cfg && !chr_on) |=> !O_FAST_BLANK_OUT;
    endproperty
    a_fblank: assert property (p_fblank) else $error("fast blank outside character");

    property p_rgb;
        (ctrl_r.osd_en && win_on && win_cfg_r[3]) |=> O_RGB.r;
    endproperty
    a_rgb: assert property (p_rgb) else $error("window red not on output");
endmodule : osd_frame_timing

//--- osd_mon_model.sv
// monitor deflection model: flyback pulse source
// assumes one clock; flyback lines change just after its edge
`timescale 1ns/1ps
module osd_mon_model #(
    parameter int LINE_CLKS = 1440,
    parameter int FRAME_LINES = 10
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // flyback outputs
    output logic o_hfly,
    output logic o_vfly
);
    int pos;
    int line;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos <= 0;
            line <= 0;
        end else if (pos == LINE_CLKS - 1) begin
            pos <= 0;
            line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
        end else begin
            pos <= pos + 1;
        end
    end
    // vertical edge lands 100 clocks into line 0, after the horizontal pulse, so line numbering is unambiguous
    assign o_hfly = pos < 8;
    assign o_vfly = line == 0 && pos >= 100;
endmodule : osd_mon_model

//--- testbench.sv
// self-checking bench for the frame timing block
// assumes the monitor model drives both flyback inputs
`timescale 1ns/1ps
`include "osd_frame_consts.svh"
module testbench;
    import osd_pkg::*;
    logic I_CLK = 0;
    logic I_RESET_N = 0;
    logic hfly;
    logic vfly;
    logic [9:0] I_ADDR = 10'h0;
    logic [15:0] I_WDATA = 16'h0;
    logic I_WR = 0;
    logic I_RD = 0;
    logic [15:0] O_RDATA;
    osd_rgb_t O_RGB;
    logic O_HALFTONE_CLOCK_OUT;
    logic O_FAST_BLANK_OUT;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] d;
    logic [15:0] v;
    logic [9:0] ra[5] = '{`OSD_A_CTRL, `OSD_A_VDLY, `OSD_A_HDLY, `OSD_A_CHGT, 10'h00b};
    logic [15:0] rv[5] = '{16'h0, 16'h4, 16'hf, 16'h10, 16'h0};
    always #12.5 I_CLK = ~I_CLK;
    osd_mon_model mon (.i_clk(I_CLK), .i_rst_n(I_RESET_N), .o_hfly(hfly), .o_vfly(vfly));
    osd_frame_timing dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_HORIZ_FLYBACK_IN(hfly),
        .I_VERT_FLYBACK_IN(vfly), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
        .O_RDATA(O_RDATA), .O_RGB(O_RGB), .O_HALFTONE_CLOCK_OUT(O_HALFTONE_CLOCK_OUT),
        .O_FAST_BLANK_OUT(O_FAST_BLANK_OUT));
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [9:0] a, input logic [15:0] w);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= w;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask : wr
    task rd(input logic [9:0] a, output logic [15:0] r);
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1 r = O_RDATA;
    endtask : rd
    // dots to clocks at 1440 clocks per line; first dot is fixed 47 plus pulse 4 plus 5 per delay step, delay 1
    function int clks(input int dots, input int mult);
        return dots * 1440 / mult;
    endfunction : clks
    task frame_check(input int mult, input int dots, input int wdots);
        int ln;
        int first;
        int hits;
        int ht;
        int e;
        ln = 0;
        first = -1;
        hits = 0;
        ht = 0;
        @(posedge vfly);
        for (int l = 1; l <= 7; l++) begin
            @(posedge hfly);
            for (int k = 0; k < 1400; k++) begin
                @(posedge I_CLK);
                #1;
                if (O_HALFTONE_CLOCK_OUT !== 1'b0) ht++;
                if (O_FAST_BLANK_OUT === 1'b1 && (ln == 0 || ln == l)) begin
                    if (ln == 0) first = k;
                    ln = l;
                    hits++;
                    check("rgb", {13'h0, O_RGB}, 16'h7);
                end
                if (O_HALFTONE_CLOCK_OUT === 1'b1 && O_FAST_BLANK_OUT === 1'b0) begin
                    check("window rgb", {13'h0, O_RGB}, 16'h4);
                end
            end
        end
        e = clks(47 + 4 + 5, mult);
        check("line", 16'(ln), 16'h5);
        check("hstart", 16'(first >= e - 1 && first <= e + 8), 16'h1);
        e = clks(dots, mult);
        check("width", 16'(hits >= e - 3 && hits <= e + 3), 16'h1);
        check("halftone", 16'(ht), 16'(3 * clks(wdots, mult)));
        $display("frame test done, mult %0d", mult);
    endtask : frame_check
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        void'($urandom(32'hc19c98f7));
        repeat (2) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], d);
            check("reset value", d, rv[i]);
        end
        wr(`OSD_A_VDLY, 16'h0);
        wr(`OSD_A_HDLY, 16'h0);
        rd(`OSD_A_VDLY, d);
        check("vdly kept", d, 16'h4);
        rd(`OSD_A_HDLY, d);
        check("hdly kept", d, 16'hf);
        repeat (4) begin
            v = 16'($urandom);
            wr(`OSD_A_COLR, v);
            rd(`OSD_A_COLR, d);
            check("colour", d, v & 16'h3f);
        end
        $display("register test done");
        wr(`OSD_A_VDLY, 16'h1);
        wr(`OSD_A_HDLY, 16'h1);
        wr(`OSD_A_COLR, 16'h7);
        for (int c = 0; c < 30; c++) wr(10'h200 | 10'(c), (c < 2 || c == 29) ? 16'h7f : 16'h0);
        // 320 mode: retrace hides the last column
        wr(`OSD_A_CTRL, 16'h1);
        frame_check(320, 20, 0);
        // 480 mode: all thirty columns fit
        wr(`OSD_A_CTRL, 16'h5);
        frame_check(480, 30, 0);
        // double width: odd columns dropped
        wr(`OSD_A_DW, 16'h1);
        frame_check(480, 20, 0);
        // red window over row 0 columns 0 to 3, fast blank on characters only
        wr(`OSD_A_WROW, 16'h0);
        wr(`OSD_A_WCOL, 16'h0300);
        wr(`OSD_A_WCFG, 16'h9);
        wr(`OSD_A_CTRL, 16'h7);
        frame_check(480, 20, 40);
        finish_test;
    end
endmodule : testbench
